// File: core/slf_frame_ctrl.sv
// frame delimiting, pair checking, sequencing and payload fifo
module slf_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  input  wire logic         i_valid,   // write request
  output logic              o_ready,   // room for one more word
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,   // word available
  input  wire logic         i_ready,   // reader takes word
  output logic      [W-1:0] o_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  // whole fifo state in one packed record
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } slf_fifo_st_t;
  slf_fifo_st_t s, next_s;
  logic wr, rd;

  assign o_ready = (s.cnt != (AW+1)'(D));
  assign o_valid = (s.cnt != '0);
  assign o_data  = s.mem[s.rp];        // straight from flip-flops

  // pointer wrap works for any depth, not only powers of two
  always_comb begin
    next_s = s;
    wr = i_valid && o_ready;
    rd = o_valid && i_ready;
    if (wr) begin
      next_s.mem[s.wp] = i_data;
      next_s.wp = (s.wp == AW'(D-1)) ? '0 : s.wp + 1'b1;
    end
    if (rd) begin
      next_s.rp = (s.rp == AW'(D-1)) ? '0 : s.rp + 1'b1;
    end
    if (wr && !rd) begin
      next_s.cnt = s.cnt + 1'b1;
    end else if (rd && !wr) begin
      next_s.cnt = s.cnt - 1'b1;
    end
  end

  // state register
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

module slf_frame_ctrl
  import slf_pkg::*;
(
  input  wire logic               i_clk,
  input  wire logic               i_reset,
  input  wire slf_pkg::slf_link_t i_link_state,  // from link state machine
  input  wire slf_pkg::slf_mode_t i_mode,
  input  wire logic               i_ext_distance, // wide counters
  input  wire logic               i_rx_valid,     // decoded character
  input  wire logic               i_rx_special,   // 1: special, 0: data
  input  wire slf_pkg::slf_char_t i_rx_code,
  input  wire logic [7:0]         i_rx_byte,
  output logic                    o_rx_accept,    // character taken
  output logic                    o_pay_valid,    // payload byte out
  input  wire logic               i_pay_ready,
  output logic [7:0]              o_pay_byte,
  output logic                    o_frame_done,   // frame closed, pulse
  output logic                    o_frame_ok,     // valid, forwardable
  output logic [7:0]              o_frame_ctrl,   // received control byte
  output logic                    o_ack_request,  // send an ACK pair
  output logic                    o_recovery,     // start recovery, pulse
  output slf_pkg::slf_cause_t     o_cause,
  output logic                    o_link_reset,
  output logic                    o_total_reset,
  output logic                    o_absolute_reset,
  output logic                    o_self_test,
  output logic [7:0]              o_link_status,
  output logic [7:0]              o_extended_receive_count_field,
  output slf_pkg::slf_seq_t       o_rx_seq,
  output slf_pkg::slf_seq_t       o_tx_seq,
  output logic [3:0]              o_tx_permit,    // one bit per frame type
  input  wire logic               i_tx_start,     // frame start request
  input  wire logic [7:0]         i_tx_ctrl,      // own or forwarded byte
  input  wire logic               i_tx_trailing,  // trailing FLAG sent
  input  wire logic               i_tx_abort,     // ABORT-FLAG sent
  output logic [7:0]              o_tx_ctrl,      // byte to transmit
  output logic                    o_tx_busy,
  output logic                    o_tx_refused
);
  // all block state in one packed record
  typedef struct packed {
    slf_pair_t       pend;       // first half of a pair seen
    slf_pair_t       last_pair;  // pair that ended on the last character
    logic [7:0]      data_cnt;   // data characters since last FLAG
    logic [3:0]      idle_cnt;   // idle FLAGs counted in Ready or Check
    logic [7:0]      ctrl;
    logic [7:0]      aux;        // second data character
    logic [7:0]      aux2;       // third data character
    logic [3:0][7:0] dly;        // holds back the check field
    logic [2:0]      dly_n;
    logic            push;
    logic [7:0]      push_byte;
    logic            done;
    logic            ok;
    logic            ack;
    logic            recov;
    slf_cause_t      cause;
    logic            lrst;
    logic            trst;
    logic            arst;
    logic            power_on_self_test;
    logic [7:0]      lstat;
    logic [7:0]      ersc;
    slf_seq_t        rx_seq;
    slf_seq_t        tx_seq;
    logic            tx_busy;
    logic [1:0]      tx_type;
    logic [7:0]      tx_ctrl;
    logic            tx_ref;
  } slf_state_t;

  slf_state_t s, next_s;
  logic       v, fin, ab, viol, drop, fifo_rdy;
  slf_pair_t  pr;
  slf_cause_t cz;
  logic [1:0] ft, rt;
  logic [7:0] lim;

  // send permission for one frame type in the current state and mode
  function automatic logic permit(input logic [1:0] t, input slf_link_t st,
                                  input slf_mode_t md);
    case (t)
      SLF_FT_CTRL: permit = (st != SLF_DISABLED);
      SLF_FT_PRIV: permit = (st == SLF_READY);
      default:     permit = (st == SLF_READY) && (md == SLF_NORMAL);
    endcase
  endfunction

  // next sequence count, two bits unless extended distance is on
  function automatic slf_seq_t bump(input slf_seq_t c, input logic ext);
    bump = ext ? slf_seq_t'(c + 8'h01)
               : {6'h00, 2'(c[SLF_SQ_HI:0] + 2'h1)};
  endfunction

  generate
    for (genvar g = 0; g < 4; g++) begin : g_perm
      assign o_tx_permit[g] = permit(2'(g), i_link_state, i_mode);
    end
  endgenerate

  // one push in flight at most: halves peak payload rate, never overflows
  assign o_rx_accept = fifo_rdy && !s.push;
  assign v = i_rx_valid && o_rx_accept;

  slf_fifo #(.W(SLF_FIFO_W), .D(SLF_FIFO_D)) u_fifo (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_valid (s.push),
    .o_ready (fifo_rdy),
    .i_data  (s.push_byte),
    .o_valid (o_pay_valid),
    .i_ready (i_pay_ready),
    .o_data  (o_pay_byte)
  );

  // receive character checks, frame close and transmit bookkeeping
  always_comb begin
    next_s = s;
    {next_s.push, next_s.done, next_s.ok, next_s.ack} = 4'h0;
    {next_s.recov, next_s.lrst, next_s.trst} = 3'h0;
    {next_s.arst, next_s.power_on_self_test, next_s.tx_ref} = 3'h0;
    next_s.cause = SLF_C_NONE;
    {fin, ab, viol, drop} = 4'h0;
    pr = SLF_P_NONE;
    cz = SLF_C_NONE;
    ft = s.ctrl[SLF_FT_HI:SLF_FT_LO];
    rt = s.ctrl[SLF_SQ_HI:0];
    lim = SLF_LEN_SAT;
    if (v) begin
      if (s.pend != SLF_P_NONE) begin
        // second half must follow at once
        next_s.pend = SLF_P_NONE;
        if (s.pend == SLF_P_ABORT && i_rx_special
            && i_rx_code == SLF_K_FLAG) begin
          ab = 1'b1;
        end else if (i_rx_special
            && ((s.pend == SLF_P_ACK && i_rx_code == SLF_K_ACK)
             || (s.pend == SLF_P_RR && i_rx_code == SLF_K_RR))) begin
          next_s.last_pair = s.pend;
        end else begin
          viol = 1'b1;
        end
      end else if (i_rx_special) begin
        next_s.last_pair = SLF_P_NONE;
        case (i_rx_code)
          SLF_K_ACK, SLF_K_RR: begin
            pr = (i_rx_code == SLF_K_ACK) ? SLF_P_ACK : SLF_P_RR;
            viol = (s.last_pair == pr)
                || (s.data_cnt == '0 && s.idle_cnt < SLF_IDLE_FLAGS);
            next_s.pend = pr;
          end
          SLF_K_ABORT: begin
            viol = (s.data_cnt == '0);
            next_s.pend = SLF_P_ABORT;
          end
          SLF_K_FLAG: fin = (s.data_cnt != '0);
          SLF_K_USER, SLF_K_SAT, SLF_K_SATR: begin
            viol = (s.data_cnt == '0 && s.idle_cnt < SLF_IDLE_FLAGS);
          end
          default: ;                                 // NUL and DIS ignored
        endcase
        // count idle FLAGs, saturating at the quiet window length
        if (i_rx_code == SLF_K_FLAG && s.data_cnt == '0
            && s.idle_cnt < SLF_IDLE_FLAGS) begin
          next_s.idle_cnt = s.idle_cnt + 4'h1;
        end
      end else begin
        // data character: first one opens a frame
        next_s.last_pair = SLF_P_NONE;
        next_s.idle_cnt = '0;
        if (s.data_cnt != SLF_LEN_SAT) begin
          next_s.data_cnt = s.data_cnt + 8'h01;
        end
        case (s.data_cnt)
          8'h00:   next_s.ctrl = i_rx_byte;
          8'h01:   next_s.aux  = i_rx_byte;
          8'h02:   next_s.aux2 = i_rx_byte;
          default: ;
        endcase
        // bytes leave only once four newer ones are held back
        if (s.data_cnt != '0) begin
          if (s.dly_n == SLF_CRC_LEN) begin
            next_s.push = 1'b1;
            next_s.push_byte = s.dly[SLF_CRC_LEN-1];
          end else begin
            next_s.dly_n = s.dly_n + 3'h1;
          end
          next_s.dly = {s.dly[2:0], i_rx_byte};
        end
      end
    end
    // close the frame on its trailing FLAG
    if (fin) begin
      case (rt)
        SLF_RT_LINK: lim = i_ext_distance ? SLF_LEN_XLINK : SLF_LEN_LINK;
        SLF_RT_RSV:  lim = SLF_LEN_SAT;
        default:     lim = SLF_LEN_PATH;
      endcase
      if (s.data_cnt < SLF_MIN_LEN) begin
        cz = SLF_C_PROTOCOL;
      end else if (ft == SLF_FT_APP && i_mode == SLF_PRIV) begin
        drop = 1'b1;
      end else if (ft != SLF_FT_CTRL
                   && s.ctrl[SLF_SQ_HI:0] != s.rx_seq[SLF_SQ_HI:0]) begin
        cz = SLF_C_SEQUENCE;
      end else if (ft == SLF_FT_RSV
                   || (ft == SLF_FT_CTRL && rt == SLF_RT_RSV)) begin
        cz = SLF_C_REJECT;
      end else if (ft == SLF_FT_CTRL && s.data_cnt > lim) begin
        cz = SLF_C_REJECT;
      end
      next_s.ok = (cz == SLF_C_NONE) && !drop;
      if (next_s.ok && ft != SLF_FT_CTRL) begin
        next_s.rx_seq = bump(s.rx_seq, i_ext_distance);
        next_s.ack = 1'b1;
      end
      if (next_s.ok && ft == SLF_FT_CTRL) begin
        // control frames act at once, no pacing
        case (rt)
          SLF_RT_LINK: begin
            next_s.lrst = 1'b1;
            next_s.lstat = s.aux;
            if (i_ext_distance) begin
              next_s.ersc = s.aux2;
            end
          end
          SLF_RT_TOTAL: next_s.trst = 1'b1;
          SLF_RT_ABS: begin
            next_s.trst = 1'b1;
            next_s.arst = 1'b1;
            next_s.power_on_self_test = 1'b1;
          end
          default: ;
        endcase
      end
      next_s.recov = (cz != SLF_C_NONE);
      next_s.cause = cz;
      next_s.done = 1'b1;
    end
    // aborted frame is dropped without counting
    if (ab) begin
      next_s.done = 1'b1;
    end
    // the same FLAG also readies the next frame
    if (fin || ab) begin
      next_s.data_cnt = '0;
      next_s.dly_n = '0;
    end
    // pairing faults only act in Ready, and win over frame results
    if (viol && i_link_state == SLF_READY) begin
      next_s.recov = 1'b1;
      next_s.cause = SLF_C_PROTOCOL;
    end
    // transmit side: regenerate the sequence field of every non-control frame
    if (i_tx_start && !s.tx_busy) begin
      if (permit(i_tx_ctrl[SLF_FT_HI:SLF_FT_LO], i_link_state, i_mode)) begin
        next_s.tx_busy = 1'b1;
        next_s.tx_type = i_tx_ctrl[SLF_FT_HI:SLF_FT_LO];
        next_s.tx_ctrl = i_tx_ctrl;
        if (i_tx_ctrl[SLF_FT_HI:SLF_FT_LO] != SLF_FT_CTRL) begin
          next_s.tx_ctrl[SLF_SQ_HI:0] = s.tx_seq[SLF_SQ_HI:0];
        end
      end else begin
        next_s.tx_ref = 1'b1;
      end
    end
    if (s.tx_busy && i_tx_trailing) begin
      next_s.tx_busy = 1'b0;
      if (s.tx_type != SLF_FT_CTRL) begin
        next_s.tx_seq = bump(s.tx_seq, i_ext_distance);
      end
    end else if (s.tx_busy && i_tx_abort) begin
      next_s.tx_busy = 1'b0;
    end
    // idle FLAG window restarts on entering Ready or Check
    if (i_link_state != SLF_READY && i_link_state != SLF_CHECK) begin
      next_s.idle_cnt = '0;
    end
    // Disabled clears counters and framing
    if (i_link_state == SLF_DISABLED) begin
      next_s.rx_seq = '0;
      next_s.tx_seq = '0;
      next_s.tx_busy = 1'b0;
      next_s.data_cnt = '0;
      next_s.dly_n = '0;
      next_s.pend = SLF_P_NONE;
      next_s.last_pair = SLF_P_NONE;
    end
  end

  // state register
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state record
  assign o_frame_done     = s.done;
  assign o_frame_ok       = s.ok;
  assign o_frame_ctrl     = s.ctrl;
  assign o_ack_request    = s.ack;
  assign o_recovery       = s.recov;
  assign o_cause          = s.cause;
  assign o_link_reset     = s.lrst;
  assign o_total_reset    = s.trst;
  assign o_absolute_reset = s.arst;
  assign o_self_test      = s.power_on_self_test;
  assign o_link_status    = s.lstat;
  assign o_extended_receive_count_field        = s.ersc;
  assign o_rx_seq         = s.rx_seq;
  assign o_tx_seq         = s.tx_seq;
  assign o_tx_ctrl        = s.tx_ctrl;
  assign o_tx_busy        = s.tx_busy;
  assign o_tx_refused     = s.tx_ref;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  pair_break_a: assert property (
    v && s.pend == SLF_P_ACK && !(i_rx_special && i_rx_code == SLF_K_ACK)
    && i_link_state == SLF_READY |=> o_recovery && o_cause == SLF_C_PROTOCOL)
    else $error("broken ACK pair not reported");
  abort_space_a: assert property (
    v && i_rx_special && i_rx_code == SLF_K_ABORT && s.pend == SLF_P_NONE
    && s.data_cnt == '0 && i_link_state == SLF_READY |=> o_recovery)
    else $error("ABORT right after FLAG not reported");
  rr_space_a: assert property (
    v && i_rx_special && i_rx_code == SLF_K_RR && s.pend == SLF_P_NONE
    && s.last_pair == SLF_P_RR && i_link_state == SLF_READY
    |=> o_recovery && o_cause == SLF_C_PROTOCOL)
    else $error("back to back RR pairs not reported");
  short_frame_a: assert property (
    fin && s.data_cnt < SLF_MIN_LEN |=> o_frame_done && !o_frame_ok)
    else $error("short frame accepted");
  rx_seq_step_a: assert property (
    o_ack_request && $past(i_link_state) != SLF_DISABLED
    |-> o_rx_seq[1:0] == 2'($past(o_rx_seq[1:0]) + 2'h1))
    else $error("receive counter did not advance with ack");
  tx_abort_a: assert property (
    s.tx_busy && i_tx_abort && !i_tx_trailing
    && i_link_state != SLF_DISABLED |=> $stable(o_tx_seq) && !o_tx_busy)
    else $error("aborted frame moved transmit counter");
  app_refuse_a: assert property (
    i_tx_start && !s.tx_busy && i_mode == SLF_PRIV
    && i_tx_ctrl[SLF_FT_HI:SLF_FT_LO] == SLF_FT_APP |=> o_tx_refused)
    else $error("application frame let through in privileged mode");
  dis_clear_a: assert property (
    i_link_state == SLF_DISABLED |=> o_tx_seq == '0 && o_rx_seq == '0)
    else $error("counters not cleared while Disabled");
  reserved_a: assert property (
    fin && s.data_cnt >= SLF_MIN_LEN && ft == SLF_FT_RSV
    && s.ctrl[1:0] == s.rx_seq[1:0] && !viol
    |=> o_recovery && o_cause == SLF_C_REJECT)
    else $error("reserved frame type not rejected");

  ack_frame_c: cover property (o_ack_request);
  abort_c: cover property (ab ##1 o_frame_done && !o_frame_ok);
  back2back_c: cover property (o_frame_ok ##[6:20] o_frame_ok);
  total_rst_c: cover property (o_total_reset);
endmodule

// File: core/slf_pkg.sv
// constants and types shared by the serial link frame control block
package slf_pkg;
  // link states driven by the separate link state machine
  typedef enum logic [1:0] {
    SLF_DISABLED, SLF_ENABLED, SLF_READY, SLF_CHECK
  } slf_link_t;
  // port operating mode
  typedef enum logic {SLF_PRIV, SLF_NORMAL} slf_mode_t;
  // special characters after 8b/10b decoding
  typedef enum logic [3:0] {
    SLF_K_FLAG, SLF_K_ABORT, SLF_K_ACK, SLF_K_RR, SLF_K_NUL,
    SLF_K_SAT, SLF_K_SATR, SLF_K_USER, SLF_K_DIS
  } slf_char_t;
  // pair tracking of indivisible special characters
  typedef enum logic [1:0] {
    SLF_P_NONE, SLF_P_ACK, SLF_P_RR, SLF_P_ABORT
  } slf_pair_t;
  // cause code reported with a link error recovery trigger
  typedef enum logic [1:0] {
    SLF_C_NONE, SLF_C_PROTOCOL, SLF_C_SEQUENCE, SLF_C_REJECT
  } slf_cause_t;
  typedef logic [7:0] slf_seq_t;      // sequence counter, up to 8 bits
  // control byte layout
  localparam int SLF_FT_HI  = 5;
  localparam int SLF_FT_LO  = 4;
  localparam int SLF_RSV_HI = 7;
  localparam int SLF_RSV_LO = 6;
  localparam int SLF_SQ_HI  = 1;      // sequence / reset type low bits
  // frame type codes
  localparam logic [1:0] SLF_FT_APP  = 2'h0;
  localparam logic [1:0] SLF_FT_RSV  = 2'h1;
  localparam logic [1:0] SLF_FT_PRIV = 2'h2;
  localparam logic [1:0] SLF_FT_CTRL = 2'h3;
  // reset type codes
  localparam logic [1:0] SLF_RT_LINK  = 2'h0;
  localparam logic [1:0] SLF_RT_TOTAL = 2'h1;
  localparam logic [1:0] SLF_RT_RSV   = 2'h2;
  localparam logic [1:0] SLF_RT_ABS   = 2'h3;
  // frame lengths in data characters
  localparam logic [7:0] SLF_MIN_LEN   = 8'h06;
  localparam logic [2:0] SLF_CRC_LEN   = 3'h4;
  localparam logic [7:0] SLF_LEN_LINK  = 8'h06; // control+status+check
  localparam logic [7:0] SLF_LEN_XLINK = 8'h07; // plus extended count
  localparam logic [7:0] SLF_LEN_PATH  = 8'h09; // control+4 path+check
  localparam logic [7:0] SLF_LEN_SAT   = 8'hFF;
  localparam logic [3:0] SLF_IDLE_FLAGS = 4'hA;
  localparam int SLF_FIFO_W = 8;
  localparam int SLF_FIFO_D = 4;
endpackage

// File: tb/slf_far_port.sv
// far-side port model: offers decoded link characters one at a time
module slf_far_port
  import slf_pkg::*;
(
  input  wire logic          i_clk,
  input  wire logic          i_accept,
  output logic               o_valid,
  output logic               o_special,
  output slf_pkg::slf_char_t o_code,
  output logic [7:0]         o_byte,
  output logic               o_hung
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_valid = 1'b0;
    o_special = 1'b0;
    o_code = SLF_K_FLAG;
    o_byte = 8'h00;
    o_hung = 1'b0;
  end
  // offer a character just after an edge, hold it until taken; the line
  // stays offered on return so pairs go out back to back
  task automatic send(input logic sp, input slf_char_t c,
                      input logic [7:0] b);
    logic a;
    int   n;
    a = 1'b0;
    n = 0;
    o_valid = 1'b1;
    o_special = sp;
    o_code = c;
    o_byte = b;
    while (!a && n < 64) begin
      @(negedge i_clk);
      a = i_accept; // ready is settled half a cycle before sampling
      @(posedge i_clk);
      n++;
    end
    if (!a) o_hung = 1'b1;
    #1;
  endtask
  // release the line; data flips so a stale byte never looks current
  task automatic idle();
    o_valid = 1'b0;
    o_byte = ~o_byte;
  endtask
endmodule

// File: tb/slf_frame_ctrl_test.sv
// self-checking bench for the frame control block
module slf_frame_ctrl_test
  import slf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       i_clk, i_reset, rv, rs, acc, pv, pr, busy, refd, hung;
  logic       tstart, ttrail, tabort, ok, ack, rec, lr, tr, ar, stt;
  slf_link_t  st;
  slf_mode_t  md;
  slf_char_t  rc;
  slf_cause_t cause;
  logic       dn, ext;                  // frame closed, wide counters
  logic [7:0] rb, tctrl, otctrl, lstat, sb, sb2, pb, fc, ersc;
  logic [7:0] pq[$];                    // payload bytes still expected
  slf_seq_t   rxs, txs;
  logic [3:0] perm;
  logic [9:0] seen; // done ok ack rec link total abs self, cause
  int         n_errors, num_checks, exp_rx, exp_tx, clr_req, clr_ack;
  slf_frame_ctrl dut_u (.i_clk(i_clk), .i_reset(i_reset),
    .i_link_state(st), .i_mode(md), .i_ext_distance(ext),
    .i_rx_valid(rv), .i_rx_special(rs), .i_rx_code(rc), .i_rx_byte(rb),
    .o_rx_accept(acc), .o_pay_valid(pv), .i_pay_ready(pr), .o_pay_byte(pb),
    .o_frame_done(dn), .o_frame_ok(ok), .o_frame_ctrl(fc), .o_ack_request(ack),
    .o_recovery(rec), .o_cause(cause), .o_link_reset(lr),
    .o_total_reset(tr), .o_absolute_reset(ar), .o_self_test(stt),
    .o_link_status(lstat), .o_extended_receive_count_field(ersc), .o_rx_seq(rxs), .o_tx_seq(txs),
    .o_tx_permit(perm), .i_tx_start(tstart), .i_tx_ctrl(tctrl),
    .i_tx_trailing(ttrail), .i_tx_abort(tabort), .o_tx_ctrl(otctrl),
    .o_tx_busy(busy), .o_tx_refused(refd));
  slf_far_port far_u (.i_clk(i_clk), .i_accept(acc), .o_valid(rv),
    .o_special(rs), .o_code(rc), .o_byte(rb), .o_hung(hung));
  always #12.5 i_clk = ~i_clk;
  // result pulses are sticky so a check need not hit the exact cycle; each
  // stands a whole cycle, so the falling edge sees it exactly once
  always @(negedge i_clk)
    if (clr_ack != clr_req) begin
      seen <= '0;
      clr_ack <= clr_req;
    end else begin
      seen <= seen | {dn, ok, ack, rec, lr, tr, ar, stt,
                      rec ? 2'(cause) : 2'h0};
    end
  // every byte the reader takes must be the next payload byte expected
  always @(negedge i_clk)
    if (pv && pr)
      chk(pb, pq.size() != 0 ? 9'(pq.pop_front()) : 9'h100);
  // the payload reader stalls at random
  always @(posedge i_clk) begin
    #1;
    pr = 1'($urandom);
  end
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (hung) n_errors++;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic step();
    @(posedge i_clk);
    #1;
  endtask
  task automatic ch(input slf_char_t c);
    far_u.send(1'b1, c, 8'h00);
  endtask
  task automatic dat(input logic [7:0] b);
    far_u.send(1'b0, SLF_K_NUL, b);
  endtask
  // let the line go quiet, then compare the collected results
  task automatic settle(input logic [8:0] e);
    far_u.idle();
    repeat (3) @(posedge i_clk);
    #1;
    chk(seen[8:0], e);
  endtask
  // idle FLAGs, then a run of special characters
  task automatic burst(input int nf, input slf_char_t q[$],
                       input logic [8:0] e);
    clr_req++;
    repeat (nf) ch(SLF_K_FLAG);
    foreach (q[i]) ch(q[i]);
    settle(e);
  endtask
  // control byte, n-1 more data characters, optional abort, FLAG; bytes
  // two to n-4 are payload, the last four are the check field
  task automatic frm(input logic [7:0] c, input int n, input logic ab,
                     input logic [8:0] e);
    logic [7:0] b;
    clr_req++;
    dat(c);
    for (int i = 1; i < n; i++) begin
      b = 8'($urandom);
      if (i == 1) sb = b;
      if (i == 2) sb2 = b;
      if (i <= n - 5) pq.push_back(b);
      dat(b);
    end
    if (ab) ch(SLF_K_ABORT);
    ch(SLF_K_FLAG);
    settle(e);
    chk({seen[9], fc}, {1'b1, c});
  endtask
  // start a frame, then end it by trailing FLAG or by abort
  task automatic tx(input logic [7:0] c, input logic ab);
    logic ctl;
    ctl = (c[5:4] == SLF_FT_CTRL);
    tctrl = c;
    tstart = 1'b1;
    step();
    tstart = 1'b0;
    chk({busy, otctrl}, {1'b1, ctl ? c : {c[7:2], 2'(exp_tx)}});
    tabort = ab;
    ttrail = !ab;
    step();
    {tabort, ttrail} = 2'h0;
    if (!ab && !ctl) exp_tx = (exp_tx + 1) % 4;
    chk({busy, txs}, {1'b0, 8'(exp_tx)});
  endtask
  task automatic refuse(input logic [7:0] c);
    tctrl = c;
    tstart = 1'b1;
    step();
    tstart = 1'b0;
    chk({refd, busy}, 17'h2);
    step();
  endtask
  function automatic logic [3:0] pexp(slf_link_t s, slf_mode_t m);
    logic a;
    a = (s == SLF_READY) && (m == SLF_NORMAL);
    return {s != SLF_DISABLED, s == SLF_READY, a, a};
  endfunction
  initial begin
    #2000000;
    n_errors++;
    end_of_test();
  end
  initial begin
    {i_clk, i_reset, tstart, ttrail, tabort, ext} = 6'h10;
    st = SLF_DISABLED;
    md = SLF_NORMAL;
    tctrl = 8'h00;
    {n_errors, num_checks, exp_rx, exp_tx} = '0;
    void'($urandom(32'hD94E02EC));
    repeat (12) @(posedge i_clk);
    #1;
    i_reset = 1'b0;
    chk({acc, rxs, txs}, 17'h10000);
    for (int s = 0; s < 8; s++) begin
      st = slf_link_t'(s[2:1]);
      md = slf_mode_t'(s[0]);
      step();
      chk(perm, pexp(st, md));
    end
    st = SLF_READY;
    burst(3, {SLF_K_RR, SLF_K_RR}, 9'h041);
    burst(12, {SLF_K_RR, SLF_K_RR, SLF_K_RR, SLF_K_RR}, 9'h041);
    burst(12, {SLF_K_ACK, SLF_K_ACK, SLF_K_ACK, SLF_K_ACK}, 9'h041);
    burst(12, {SLF_K_ABORT, SLF_K_FLAG}, 9'h041);
    burst(12, {SLF_K_ACK, SLF_K_FLAG}, 9'h041);
    st = SLF_CHECK;
    burst(12, {SLF_K_ABORT, SLF_K_FLAG}, 9'h000);
    st = SLF_READY;
    burst(12, {SLF_K_ACK, SLF_K_ACK, SLF_K_SAT, SLF_K_FLAG}, 9'h0);
    for (int i = 0; i < 6; i++) begin
      frm({2'h0, $urandom_range(0, 1) ? SLF_FT_PRIV : SLF_FT_APP, 2'h0,
           2'(exp_rx)}, 6 + $urandom_range(0, 6), 1'b0, 9'h180);
      exp_rx = (exp_rx + 1) % 4;
      chk(rxs, 8'(exp_rx));
    end
    frm({6'h00, 2'(exp_rx + 1)}, 6, 1'b0, 9'h042);
    frm({6'h00, 2'(exp_rx)}, 5, 1'b0, 9'h041);
    frm({6'h00, 2'(exp_rx)}, 8, 1'b1, 9'h000);
    md = SLF_PRIV;
    frm({6'h00, 2'(exp_rx)}, 6, 1'b0, 9'h000);
    md = SLF_NORMAL;
    chk(rxs, 8'(exp_rx));
    frm({6'h04, 2'(exp_rx)}, 6, 1'b0, 9'h043);
    frm(8'h32, 6, 1'b0, 9'h043);
    frm(8'h30, 7, 1'b0, 9'h043);
    frm(8'h31, 6, 1'b0, 9'h110);
    frm(8'h33, 6, 1'b0, 9'h11C);
    frm(8'h30, 6, 1'b0, 9'h120);
    chk(lstat, sb);
    // extended distance: longer link reset, receive counter past modulo 4
    ext = 1'b1;
    frm(8'h30, 7, 1'b0, 9'h120);
    chk({lstat, ersc}, {sb, sb2});
    repeat (2) begin
      frm({6'h00, 2'(exp_rx)}, 6, 1'b0, 9'h180);
      exp_rx++;
    end
    chk(rxs, 8'(exp_rx));
    ext = 1'b0;
    st = SLF_DISABLED;
    repeat (2) step();
    chk({rxs, txs}, 17'h0);
    st = SLF_READY;
    for (int i = 0; i < 8; i++)
      tx({2'h0, 6'($urandom)}, $urandom_range(0, 3) == 0);
    md = SLF_PRIV;
    refuse(8'h00);
    md = SLF_NORMAL;
    st = SLF_ENABLED;
    refuse(8'h20);
    tx(8'h31, 1'b0);
    repeat (16) step();
    chk(17'(pq.size()), 17'h0);
    st = SLF_DISABLED;
    step();
    chk(txs, 17'h0);
    end_of_test();
  end
endmodule
